// ---- include/ebu_pkg.sv ----
// package for the external bus unit: carriers, states and timing counts
package ebu_pkg;

    // ----------------------------------------------------------------
    // widths
    // ----------------------------------------------------------------
    localparam int ADDR_W = 26;
    localparam int DATA_W = 32;
    localparam int CS_W   = 6;
    localparam int LANE_W = 4;

    // ----------------------------------------------------------------
    // timing counts in core clocks
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 40;
    localparam int ACC_TIME_NS       = 120;
    localparam int ACC_CYCLES        = (ACC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FIRST_TIME_NS     = 200;
    localparam int FIRST_CYCLES      = (FIRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BCLK_HALF_NS      = 40;
    localparam int BCLK_HALF_CYCLES  = (BCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W             = 8;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int          CS_SHARED_LO   = 2;
    localparam int          CS_ACK_BIT     = 4;
    localparam logic [3:0]  LANES_IDLE     = 4'hF;
    localparam logic [5:0]  CS_IDLE        = 6'h3F;
    localparam logic [1:0]  DRAM_SEL_IDLE  = 2'h3;
    localparam logic [7:0]  BURST_LEN_RST  = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        logic              write;
        logic              burst;
        logic [2:0]        cs;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [LANE_W-1:0] lanes;
        logic [7:0]        beats;
    } ebu_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic              dout_en;
        logic [LANE_W-1:0] lanes_n;
        logic              oe_n;
        logic              rw;
        logic [CS_W-1:0]   cs_n;
        logic              lba_n;
        logic              bclk;
    } ebu_pins_t;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'b000001,
        ST_SETUP  = 6'b000010,
        ST_ACCESS = 6'b000100,
        ST_LATCH  = 6'b001000,
        ST_BURST  = 6'b010000,
        ST_DONE   = 6'b100000
    } ebu_state_t;

endpackage

// ---- core/ebu_sync.sv ----
// two-stage synchroniser for pin inputs
module ebu_sync
    import ebu_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input  wire logic         CORE_CLK_I,
    input  wire logic         NRST_I,
    input  wire logic [W-1:0] D_I,
    output logic      [W-1:0] Q_O
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            meta_reg <= RST_VAL;
            Q_O      <= RST_VAL;
        end else begin
            meta_reg <= D_I;
            Q_O      <= meta_reg;
        end
    end

endmodule // ebu_sync

// ---- core/ebu_core.sv ----
// external bus unit: chip selects, byte strobes and burst control
module ebu_core
    import ebu_pkg::*;
#(
    parameter int ACC_CNT   = ACC_CYCLES,
    parameter int FIRST_CNT = FIRST_CYCLES,
    parameter int HALF_CNT  = BCLK_HALF_CYCLES
) (
    input  wire logic              CORE_CLK_I,
    input  wire logic              NRST_I,
    input  wire ebu_req_t          REQ_I,
    input  wire logic              FUNC_MUX_CS_I,
    input  wire logic              FUNC_MUX_ACK_I,
    output logic                   REQ_READY_O,
    output logic [DATA_W-1:0]      RDATA_O,
    output logic                   RDATA_VALID_O,
    output logic                   DONE_O,
    input  wire logic [DATA_W-1:0] DATA_IN_I,
    input  wire logic              DATA_ACK_IN_N_I,
    input  wire logic              BURST_RESTART_REQUEST_N_I,
    output logic [ADDR_W-1:0]      ADDR_O,
    output logic [DATA_W-1:0]      DATA_O,
    output logic                   DATA_OE_O,
    output logic                   BYTE_LANE_STROBE_HI_O,
    output logic                   BYTE_LANE_STROBE_2_O,
    output logic                   BYTE_LANE_STROBE_1_O,
    output logic                   BYTE_LANE_STROBE_LO_O,
    output logic                   OE_N_O,
    output logic                   RW_O,
    output logic [CS_W-1:0]        CS_N_O,
    output logic [1:0]             DRAM_BANK_SELECT_N_O,
    output logic                   BURST_ADDRESS_LATCH_N_O,
    output logic                   BURST_CLK_O
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        ebu_state_t        st;
        ebu_req_t          req;
        logic [CNT_W-1:0]  cnt;
        logic [CNT_W-1:0]  half;
        logic              mux_cs;
        logic              mux_ack;
        ebu_pins_t         pins;
        logic [1:0]        dram_n;
        logic              ready;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
        logic              done;
    } ebu_core_t;

    ebu_core_t s_reg;
    ebu_core_t s_next;

    logic [DATA_W-1:0] din_s;
    logic              ack_n_s;
    logic              rst_n_s;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    ebu_sync #(.W(DATA_W), .RST_VAL('0)) u_sync_data (
        .CORE_CLK_I (CORE_CLK_I),
        .NRST_I     (NRST_I),
        .D_I        (DATA_IN_I),
        .Q_O        (din_s)
    );

    ebu_sync #(.W(2), .RST_VAL(2'h3)) u_sync_ctl (
        .CORE_CLK_I (CORE_CLK_I),
        .NRST_I     (NRST_I),
        .D_I        ({DATA_ACK_IN_N_I, BURST_RESTART_REQUEST_N_I}),
        .Q_O        ({ack_n_s, rst_n_s})
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [CS_W-1:0] cs_decode(input logic [2:0] idx, input logic mux_cs, input logic mux_ack);
        logic [CS_W-1:0] v;
        v = CS_IDLE;
        if (idx < 3'(CS_W)) begin
            v[idx] = 1'b0;
        end
        if (!mux_cs) begin
            v[3:2] = 2'h3;
        end
        if (mux_ack) begin
            v[CS_ACK_BIT] = 1'b1;
        end
        return v;
    endfunction

    function automatic logic [CNT_W-1:0] cyc(input int n);
        return (n < 1) ? CNT_W'(1) : CNT_W'(n);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_next        = s_reg;
        s_next.done   = 1'b0;
        s_next.rvalid = 1'b0;
        s_next.mux_cs = FUNC_MUX_CS_I;
        s_next.mux_ack = FUNC_MUX_ACK_I;
        s_next.dram_n = s_reg.mux_cs ? DRAM_SEL_IDLE : s_reg.dram_n;
        case (s_reg.st)
            ST_IDLE: begin
                s_next.ready = 1'b1;
                s_next.pins.bclk = 1'b0;
                if (REQ_I.valid && s_reg.ready) begin
                    s_next.req   = REQ_I;
                    s_next.ready = 1'b0;
                    s_next.pins.addr = REQ_I.addr;
                    s_next.pins.rw = ~REQ_I.write;
                    s_next.pins.dout = REQ_I.wdata;
                    s_next.pins.dout_en = REQ_I.write;
                    s_next.pins.cs_n = cs_decode(REQ_I.cs, s_reg.mux_cs, s_reg.mux_ack);
                    s_next.cnt = REQ_I.burst ? cyc(FIRST_CNT) : cyc(ACC_CNT);
                    s_next.st  = REQ_I.burst ? ST_LATCH : ST_SETUP;
                    s_next.pins.lba_n = ~REQ_I.burst;
                end
            end
            ST_SETUP: begin
                s_next.pins.lanes_n = ~s_reg.req.lanes;
                s_next.pins.oe_n = s_reg.req.write;
                s_next.st = ST_ACCESS;
            end
            ST_ACCESS: begin
                if (s_reg.cnt > CNT_W'(1)) begin
                    s_next.cnt = s_reg.cnt - CNT_W'(1);
                end else if (!s_reg.mux_ack || !ack_n_s) begin
                    s_next.rdata  = din_s;
                    s_next.rvalid = ~s_reg.req.write;
                    s_next.st     = ST_DONE;
                end
            end
            ST_LATCH: begin
                s_next.pins.lba_n = 1'b1;
                s_next.pins.lanes_n = ~s_reg.req.lanes;
                s_next.pins.oe_n = s_reg.req.write;
                s_next.half = cyc(HALF_CNT);
                s_next.st = ST_BURST;
            end
            ST_BURST: begin
                if (s_reg.half > CNT_W'(1)) begin
                    s_next.half = s_reg.half - CNT_W'(1);
                end else begin
                    s_next.half = cyc(HALF_CNT);
                    s_next.pins.bclk = ~s_reg.pins.bclk;
                    if (s_reg.pins.bclk) begin
                        if (!rst_n_s) begin
                            s_next.cnt = cyc(FIRST_CNT);
                            s_next.pins.lba_n = 1'b0;
                            s_next.pins.bclk = 1'b0;
                            s_next.st = ST_LATCH;
                        end else if (s_reg.cnt > CNT_W'(1)) begin
                            s_next.cnt = s_reg.cnt - CNT_W'(1);
                        end else begin
                            s_next.rdata  = din_s;
                            s_next.rvalid = ~s_reg.req.write;
                            s_next.pins.addr = s_reg.pins.addr + ADDR_W'(LANE_W);
                            s_next.cnt = cyc(1);
                            if (s_reg.req.beats <= 8'h01) begin
                                s_next.st = ST_DONE;
                            end else begin
                                s_next.req.beats = s_reg.req.beats - 8'h01;
                            end
                        end
                    end
                end
            end
            ST_DONE: begin
                s_next.pins.lanes_n = LANES_IDLE;
                s_next.pins.oe_n = 1'b1;
                s_next.pins.cs_n = CS_IDLE;
                s_next.pins.dout_en = 1'b0;
                s_next.pins.rw = 1'b1;
                s_next.pins.bclk = 1'b0;
                s_next.pins.lba_n = 1'b1;
                s_next.done = 1'b1;
                s_next.st = ST_IDLE;
            end
            default: begin
                s_next.st = ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            s_reg              <= '0;
            s_reg.st           <= ST_IDLE;
            s_reg.req.beats    <= BURST_LEN_RST;
            s_reg.pins.lanes_n <= LANES_IDLE;
            s_reg.pins.oe_n    <= 1'b1;
            s_reg.pins.rw      <= 1'b1;
            s_reg.pins.cs_n    <= CS_IDLE;
            s_reg.pins.lba_n   <= 1'b1;
            s_reg.dram_n       <= DRAM_SEL_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign REQ_READY_O             = s_reg.ready;
    assign RDATA_O                 = s_reg.rdata;
    assign RDATA_VALID_O           = s_reg.rvalid;
    assign DONE_O                  = s_reg.done;
    assign ADDR_O                  = s_reg.pins.addr;
    assign DATA_O                  = s_reg.pins.dout;
    assign DATA_OE_O               = s_reg.pins.dout_en;
    assign BYTE_LANE_STROBE_HI_O   = s_reg.pins.lanes_n[3];
    assign BYTE_LANE_STROBE_2_O    = s_reg.pins.lanes_n[2];
    assign BYTE_LANE_STROBE_1_O    = s_reg.pins.lanes_n[1];
    assign BYTE_LANE_STROBE_LO_O   = s_reg.pins.lanes_n[0];
    assign OE_N_O                  = s_reg.pins.oe_n;
    assign RW_O                    = s_reg.pins.rw;
    assign CS_N_O                  = s_reg.pins.cs_n;
    assign DRAM_BANK_SELECT_N_O    = s_reg.dram_n;
    assign BURST_ADDRESS_LATCH_N_O = s_reg.pins.lba_n;
    assign BURST_CLK_O             = s_reg.pins.bclk;

endmodule // ebu_core

// ---- dv/ebu_props.sv ----
// assertion checker for the external bus unit pins
module ebu_props
    import ebu_pkg::*;
(
    input wire logic              CORE_CLK_I,
    input wire logic              NRST_I,
    input wire ebu_req_t          REQ_I,
    input wire logic              FUNC_MUX_CS_I,
    input wire logic              FUNC_MUX_ACK_I,
    input wire logic              REQ_READY_O,
    input wire logic              DONE_O,
    input wire logic [ADDR_W-1:0] ADDR_O,
    input wire logic              DATA_OE_O,
    input wire logic              BYTE_LANE_STROBE_HI_O,
    input wire logic              BYTE_LANE_STROBE_2_O,
    input wire logic              BYTE_LANE_STROBE_1_O,
    input wire logic              BYTE_LANE_STROBE_LO_O,
    input wire logic              OE_N_O,
    input wire logic              RW_O,
    input wire logic [CS_W-1:0]   CS_N_O,
    input wire logic              BURST_ADDRESS_LATCH_N_O,
    input wire logic              BURST_CLK_O
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------------------------------
    // helper state and assertions
    // ----------------------------------------------------------------
    logic [3:0] stb_n;
    logic [3:0] lanes_reg;
    logic       burst_reg;
    logic       take;
    assign stb_n = {BYTE_LANE_STROBE_HI_O, BYTE_LANE_STROBE_2_O, BYTE_LANE_STROBE_1_O, BYTE_LANE_STROBE_LO_O};
    assign take  = REQ_I.valid && REQ_READY_O;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            lanes_reg <= 4'h0;
            burst_reg <= 1'b0;
        end else if (take) begin
            lanes_reg <= REQ_I.lanes;
            burst_reg <= REQ_I.burst;
        end
    end
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!NRST_I);
    a_idle_strobes: assert property (REQ_READY_O |-> stb_n == LANES_IDLE && OE_N_O)
        else $error("strobe or output enable active while idle");
    a_lane_map: assert property (!burst_reg && stb_n != LANES_IDLE |-> ~stb_n == lanes_reg)
        else $error("byte strobes do not match requested lanes");
    a_read_dir: assert property (!OE_N_O |-> RW_O && !DATA_OE_O)
        else $error("direction not read while output enable low");
    a_write_dir: assert property (DATA_OE_O |-> !RW_O && OE_N_O)
        else $error("direction not write while data driven");
    a_read_oe: assert property (take && !REQ_I.write && !REQ_I.burst |-> ##2 !OE_N_O)
        else $error("output enable late on read");
    a_shared_cs: assert property (!FUNC_MUX_CS_I && !$past(FUNC_MUX_CS_I) && !$past(FUNC_MUX_CS_I, 2)
        |-> CS_N_O[3:2] == 2'h3)
        else $error("shared select driven in dram use");
    a_ack_pin: assert property (FUNC_MUX_ACK_I && $past(FUNC_MUX_ACK_I) && $past(FUNC_MUX_ACK_I, 2)
        |-> CS_N_O[CS_ACK_BIT])
        else $error("select 4 driven in acknowledge use");
    a_bclk_idle: assert property (REQ_READY_O |-> !BURST_CLK_O && BURST_ADDRESS_LATCH_N_O)
        else $error("burst clock or latch active while idle");
    a_latch_addr: assert property ($fell(BURST_ADDRESS_LATCH_N_O) && $past(REQ_READY_O)
        |-> ADDR_O == $past(REQ_I.addr))
        else $error("latch strobe without start address");
    a_done_bound: assert property (take |=> !REQ_READY_O ##[3:200] DONE_O)
        else $error("access did not complete in time");
    c_burst: cover property (take && REQ_I.burst);
    c_restart: cover property ($fell(BURST_ADDRESS_LATCH_N_O) && !$past(REQ_READY_O));
    c_ack_done: cover property (FUNC_MUX_ACK_I && DONE_O);
endmodule // ebu_props

bind ebu_core ebu_props u_props (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .REQ_I(REQ_I),
    .FUNC_MUX_CS_I(FUNC_MUX_CS_I), .FUNC_MUX_ACK_I(FUNC_MUX_ACK_I), .REQ_READY_O(REQ_READY_O),
    .DONE_O(DONE_O), .ADDR_O(ADDR_O), .DATA_OE_O(DATA_OE_O), .BYTE_LANE_STROBE_HI_O(BYTE_LANE_STROBE_HI_O),
    .BYTE_LANE_STROBE_2_O(BYTE_LANE_STROBE_2_O), .BYTE_LANE_STROBE_1_O(BYTE_LANE_STROBE_1_O),
    .BYTE_LANE_STROBE_LO_O(BYTE_LANE_STROBE_LO_O), .OE_N_O(OE_N_O), .RW_O(RW_O), .CS_N_O(CS_N_O),
    .BURST_ADDRESS_LATCH_N_O(BURST_ADDRESS_LATCH_N_O), .BURST_CLK_O(BURST_CLK_O));

// ---- dv/ebu_mem_model.sv ----
// partner model: burst-capable memory answering the external bus pins
module ebu_mem_model
    import ebu_pkg::*;
(
    input  wire logic              CORE_CLK_I,
    input  wire logic              NRST_I,
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic              OE_N_I,
    input  wire logic              ACT_I,
    input  wire logic              BCLK_I,
    input  wire logic [31:0]       ACK_DELAY_I,
    input  wire logic              RESTART_CMD_I,
    output logic      [DATA_W-1:0] DATA_O,
    output logic                   ACK_N_O,
    output logic                   RESTART_N_O
);
    timeunit 1ns;
    timeprecision 1ns;
    int                act_cnt;
    logic              bclk_q;
    logic [DATA_W-1:0] word;
    logic [DATA_W-1:0] held_q;
    // word follows address while enabled, inverse once released
    assign word   = {~ADDR_I[15:0], ADDR_I[15:0]};
    assign DATA_O = OE_N_I ? held_q : word;
    always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            held_q      <= 32'h5A5A_A5A5;
            ACK_N_O     <= 1'b1;
            RESTART_N_O <= 1'b1;
            act_cnt     <= 0;
            bclk_q      <= 1'b0;
        end else begin
            bclk_q <= BCLK_I;
            if (!OE_N_I) held_q <= ~word;
            act_cnt <= ACT_I ? act_cnt + 1 : 0;
            ACK_N_O <= !(ACT_I && act_cnt >= ACK_DELAY_I);
            // restart held from one falling burst clock to the next
            if (bclk_q && !BCLK_I) RESTART_N_O <= !RESTART_CMD_I;
        end
    end
endmodule // ebu_mem_model

// ---- dv/external_bus_interface_signals_bench.sv ----
// self-checking bench for the external bus unit
module external_bus_interface_signals_bench
    import ebu_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk = 1'b0;
    logic              nrst = 1'b0;
    ebu_req_t          req;
    logic              mux_cs, mux_ack, restart_cmd, ready, rvalid, done, data_oe;
    logic              s_hi, s_2, s_1, s_lo, oe_n, rw, latch_n, bclk, ack_n, rst_n;
    logic [DATA_W-1:0] rdata, din, dout, wexp;
    logic [ADDR_W-1:0] addr;
    logic [CS_W-1:0]   cs_n, cs_seen;
    logic [1:0]        dram_n;
    logic [DATA_W-1:0] exp_q[$];
    int                errors, samples_checked, ack_delay, latch_falls, bclk_rises, lat, i;
    int                seed = 32'hd3ab;
    localparam int     BCLK_HALF = 160 / CLK_PERIOD_NS;
    always #20 clk = ~clk;
    ebu_core #(.HALF_CNT(BCLK_HALF)) dut (.CORE_CLK_I(clk), .NRST_I(nrst), .REQ_I(req),
        .FUNC_MUX_CS_I(mux_cs), .FUNC_MUX_ACK_I(mux_ack),
        .REQ_READY_O(ready), .RDATA_O(rdata), .RDATA_VALID_O(rvalid), .DONE_O(done), .DATA_IN_I(din),
        .DATA_ACK_IN_N_I(ack_n), .BURST_RESTART_REQUEST_N_I(rst_n), .ADDR_O(addr), .DATA_O(dout), .DATA_OE_O(data_oe),
        .BYTE_LANE_STROBE_HI_O(s_hi), .BYTE_LANE_STROBE_2_O(s_2), .BYTE_LANE_STROBE_1_O(s_1),
        .BYTE_LANE_STROBE_LO_O(s_lo), .OE_N_O(oe_n), .RW_O(rw), .CS_N_O(cs_n), .DRAM_BANK_SELECT_N_O(dram_n),
        .BURST_ADDRESS_LATCH_N_O(latch_n), .BURST_CLK_O(bclk));
    ebu_mem_model u_mem (.CORE_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .OE_N_I(oe_n),
        .ACT_I({s_hi, s_2, s_1, s_lo} != LANES_IDLE), .BCLK_I(bclk), .ACK_DELAY_I(ack_delay),
        .RESTART_CMD_I(restart_cmd), .DATA_O(din), .ACK_N_O(ack_n), .RESTART_N_O(rst_n));
    // ----------------------------------------------------------------
    // checking helpers and pin monitor
    // ----------------------------------------------------------------
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        if (rvalid === 1'b1) check(exp_q.size() > 0 && rdata === exp_q.pop_front(), "read word");
        if (cs_n !== CS_IDLE) cs_seen = cs_n;
        if (data_oe === 1'b1 && {s_hi, s_2, s_1, s_lo} !== LANES_IDLE) check(dout === wexp && rw === 1'b0, "write");
        if ($fell(latch_n)) latch_falls++;
        if ($rose(bclk)) bclk_rises++;
    end
    task automatic access(input logic wr, input logic bu, input logic [2:0] cs, input int beats);
        logic [ADDR_W-1:0] a;
        int                n;
        a = {10'h000, 14'($random(seed)), 2'b00};
        wexp = $random(seed);
        cs_seen = CS_IDLE;
        latch_falls = 0;
        bclk_rises = 0;
        exp_q.delete();
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n >= 200) begin
            check(1'b0, "ready timeout");
            give_verdict();
        end
        for (n = 0; n < beats && !wr; n++) exp_q.push_back({~16'(a + 26'(4 * n)), 16'(a + 26'(4 * n))});
        req = '{valid: 1'b1, write: wr, burst: bu, cs: cs, addr: a, wdata: wexp,
                lanes: bu ? 4'hF : 4'($random(seed)) | 4'h1, beats: 8'(beats)};
        @(negedge clk);
        req.valid = 1'b0;
        lat = 1;
        while (done !== 1'b1 && lat < 400) begin
            @(negedge clk);
            lat++;
        end
        if (lat >= 400) check(1'b0, "access timeout");
        if (lat >= 400) give_verdict();
        @(negedge clk);
        check(exp_q.size() == 0, "missing read words");
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        req = '0;
        mux_cs = 1'b0;
        mux_ack = 1'b0;
        restart_cmd = 1'b0;
        ack_delay = 0;
        repeat (12) @(negedge clk);
        check(cs_n === CS_IDLE && dram_n === DRAM_SEL_IDLE && {s_hi, s_2, s_1, s_lo} === LANES_IDLE, "reset");
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        for (i = 2; i < 4; i++) begin
            access(1'b1, 1'b0, 3'(i), 1);
            check(cs_seen === CS_IDLE, "shared select driven");
        end
        mux_cs = 1'b1;
        for (i = 0; i < 12; i++) begin
            access(i < 6, 1'b0, 3'(i % 6), 1);
            check(cs_seen === ~(6'h01 << (i % 6)), "chip select");
        end
        $display("test singles done");
        mux_ack = 1'b1;
        ack_delay = 8;
        @(negedge clk);
        access(1'b0, 1'b0, 3'h4, 1);
        check(cs_seen === CS_IDLE && lat >= ack_delay + 4, "acknowledge read");
        access(1'b1, 1'b0, 3'h1, 1);
        check(lat >= ack_delay + 4, "acknowledge write");
        mux_ack = 1'b0;
        $display("test acknowledge done");
        access(1'b0, 1'b1, 3'h0, 4);
        check(latch_falls == 1 && bclk_rises > 0, "burst framing");
        fork
            access(1'b0, 1'b1, 3'h0, 6);
            begin
                repeat (18) @(negedge clk);
                restart_cmd = 1'b1;
                repeat (2) @(negedge clk);
                restart_cmd = 1'b0;
            end
        join
        check(latch_falls == 2, "restart relatch");
        $display("test bursts done");
        give_verdict();
    end
endmodule // external_bus_interface_signals_bench
